// ---- verilog/tmr_pkg.sv ----
package tmr_pkg;

    // ------------------------------------------------------------
    // Register map (byte addresses on the 32-bit bus)
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_COUNT_LOW   = 8'h00;
    localparam logic [7:0] ADDR_COUNT_HIGH  = 8'h04;
    localparam logic [7:0] ADDR_INT_STATUS  = 8'h08;
    localparam logic [7:0] ADDR_INT_CLEAR   = 8'h0c;
    localparam logic [7:0] ADDR_CONTROL     = 8'h10;
    localparam logic [7:0] ADDR_INT_ENABLE  = 8'h14;
    localparam logic [7:0] ADDR_PORT_CTRL   = 8'h18;

    // ------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------
    localparam int         OVF_BIT          = 0;
    localparam int         PORT_DIR_LSB     = 6;
    localparam int         PORT_DATA_LSB    = 4;
    localparam logic [7:0] CONTROL_RESET    = 8'h00;
    localparam logic [7:0] CONTROL_WMASK    = 8'h3f;
    localparam logic [7:0] PORT_CTRL_RESET  = 8'hc0;
    localparam logic [7:0] PORT_CTRL_WMASK  = 8'hf0;
    localparam logic [15:0] COUNT_ALL_ONES  = 16'hffff;

    // ------------------------------------------------------------
    // Instruction cycle phases
    // ------------------------------------------------------------
    localparam logic [1:0] PHASE_Q2         = 2'h1;
    localparam logic [1:0] PHASE_Q4         = 2'h3;

    // ------------------------------------------------------------
    // Bus answers
    // ------------------------------------------------------------
    localparam logic [1:0] RESP_OKAY        = 2'h0;
    localparam logic [1:0] RESP_SLVERR      = 2'h2;

    typedef enum logic [1:0] {
        PRESC_DIV1,
        PRESC_DIV2,
        PRESC_DIV4,
        PRESC_DIV8
    } tmr_presc_t;

    typedef struct packed {
        logic [1:0] unused;
        tmr_presc_t prescale_select;
        logic       osc_enable;
        logic       sync_disable;
        logic       clock_source_select;
        logic       run_bit;
    } tmr_ctrl_t;

endpackage

// ---- verilog/tmr_prescaler.sv ----
`timescale 1ns/1ps
module tmr_prescaler (
    input  wire logic              aclk,
    input  wire logic              aresetn,
    input  wire logic              in_level,
    input  wire logic              clear,
    input  wire tmr_pkg::tmr_presc_t sel,
    output logic                   out_level
);

    logic [2:0] stage_reg;
    logic       in_prev_reg;
    logic       in_rise;
    logic       sel_level;

    assign in_rise = in_level & ~in_prev_reg;

    assign sel_level = (sel == tmr_pkg::PRESC_DIV1) ? in_level     :
                       (sel == tmr_pkg::PRESC_DIV2) ? stage_reg[0] :
                       (sel == tmr_pkg::PRESC_DIV4) ? stage_reg[1] : stage_reg[2];

    // ripple stages counted up once per input rise; each stage toggles half as often as the one below
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            stage_reg   <= 3'h0;
            in_prev_reg <= 1'b0;
            out_level   <= 1'b0;
        end else begin
            in_prev_reg <= in_level;
            out_level   <= sel_level;
            if (clear) begin
                stage_reg <= 3'h0;
            end else if (in_rise) begin
                stage_reg <= stage_reg + 3'h1;
            end
        end
    end

    a_presc_clear: assert property (@(posedge aclk) disable iff (!aresetn)
        clear |=> stage_reg == 3'h0)
        else $error("prescaler not cleared");

    // stage advances only on a rise
    a_presc_step: assert property (@(posedge aclk) disable iff (!aresetn)
        !clear && !in_rise |=> $stable(stage_reg))
        else $error("prescaler moved without input edge");

endmodule

// ---- verilog/tmr_timer16.sv ----
// The AXI4-Lite register port was left to the implementer.
`timescale 1ns/1ps
// Notes on behaviour
// - Sixteen-bit up count from two readable, writable bytes; wraps all-ones to zero.
// - Each wrap sets a sticky overflow flag, status bit 0, until software clears it.
// - Overflow interrupt reaches the output only while enable bit 0 is set.
// - Control bit 1 picks instruction clock (0) or external rising edges (1).
// - Timer mode advances once per instruction cycle, four clocks, after prescaling.
// - Control bit 0 runs the counter; cleared, the count holds.
// - Capture/compare reset input clears the count.
// - Oscillator enable forces both oscillator pins to inputs, ignoring direction bits.
// - Control bits 5:4 divide the input by 1, 2, 4 or 8.
// - Sync bit 2 ignored in timer mode; in counter mode 0 syncs, 1 does not.
// - Counter source is oscillator input pin with oscillator on, else external pin.
// - Prescaler is a ripple counter; synchronisation follows it.
// - Synchronised counter stops in sleep; in counter mode the prescaler keeps counting, in timer mode its input is held low.
// - Prescaler output sampled on phases Q2 and Q4; count advances shortly after.
// - Control bit 3 enables the low-power oscillator on both pins.
// - Unsynchronised counter keeps counting in sleep and its overflow interrupt wakes.
// - Writing either count byte clears the prescaler.
// - Reset clears control to zero; count bytes keep their value through it.
module tmr_timer16 (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic        compare_reset,
    input  wire logic        sleep,
    input  wire logic        osc_input_pin_i,
    output logic             osc_input_pin_o,
    output logic             osc_input_pin_oe,
    input  wire logic        external_clock_pin_i,
    output logic             external_clock_pin_o,
    output logic             external_clock_pin_oe,
    output logic             osc_amp_enable,
    output logic             irq
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    tmr_pkg::tmr_ctrl_t ctrl_reg;
    logic [15:0]        sixteen_bit_count_reg;
    logic               overflow_flag_reg;
    logic               overflow_int_enable_reg;
    logic [7:0]         port_ctrl_reg;
    logic [1:0]         q_phase_reg;
    logic               presc_out;
    logic               presc_prev_reg;
    logic               samp_reg;
    logic               samp_prev_reg;
    logic [1:0]         count_known_reg;

    logic               aw_held_reg;
    logic [7:0]         aw_addr_reg;
    logic               w_held_reg;
    logic [7:0]         w_data_reg;
    logic               w_lane0_reg;

    // ------------------------------------------------------------
    // Write and read channel handshakes
    // ------------------------------------------------------------
    logic aw_take;
    logic w_take;
    logic do_write;
    logic aw_held_next;
    logic w_held_next;
    logic bvalid_next;
    logic ar_take;
    logic rvalid_next;

    assign aw_take      = s_axi_awvalid & s_axi_awready;
    assign w_take       = s_axi_wvalid & s_axi_wready;
    assign do_write     = aw_held_reg & w_held_reg & ~s_axi_bvalid;
    assign aw_held_next = (aw_held_reg | aw_take) & ~do_write;
    assign w_held_next  = (w_held_reg | w_take) & ~do_write;
    assign bvalid_next  = do_write | (s_axi_bvalid & ~s_axi_bready);
    assign ar_take      = s_axi_arvalid & s_axi_arready;
    assign rvalid_next  = ar_take | (s_axi_rvalid & ~s_axi_rready);

    // ------------------------------------------------------------
    // Write decode
    // ------------------------------------------------------------
    logic wr_en;
    logic wr_low;
    logic wr_high;
    logic wr_clear;
    logic wr_ctrl;
    logic wr_enable;
    logic wr_port;
    logic wr_mapped;
    logic count_write;

    assign wr_en       = do_write & w_lane0_reg;
    assign wr_low      = wr_en & (aw_addr_reg == tmr_pkg::ADDR_COUNT_LOW);
    assign wr_high     = wr_en & (aw_addr_reg == tmr_pkg::ADDR_COUNT_HIGH);
    assign wr_clear    = wr_en & (aw_addr_reg == tmr_pkg::ADDR_INT_CLEAR);
    assign wr_ctrl     = wr_en & (aw_addr_reg == tmr_pkg::ADDR_CONTROL);
    assign wr_enable   = wr_en & (aw_addr_reg == tmr_pkg::ADDR_INT_ENABLE);
    assign wr_port     = wr_en & (aw_addr_reg == tmr_pkg::ADDR_PORT_CTRL);
    assign count_write = wr_low | wr_high;
    assign wr_mapped   = (aw_addr_reg == tmr_pkg::ADDR_COUNT_LOW)  ||
                         (aw_addr_reg == tmr_pkg::ADDR_COUNT_HIGH) ||
                         (aw_addr_reg == tmr_pkg::ADDR_INT_STATUS) ||
                         (aw_addr_reg == tmr_pkg::ADDR_INT_CLEAR)  ||
                         (aw_addr_reg == tmr_pkg::ADDR_CONTROL)    ||
                         (aw_addr_reg == tmr_pkg::ADDR_INT_ENABLE) ||
                         (aw_addr_reg == tmr_pkg::ADDR_PORT_CTRL);

    // ------------------------------------------------------------
    // Read selection
    // ------------------------------------------------------------
    logic       rd_mapped;
    logic [7:0] rd_value;

    assign rd_mapped = (s_axi_araddr == tmr_pkg::ADDR_COUNT_LOW)  ||
                       (s_axi_araddr == tmr_pkg::ADDR_COUNT_HIGH) ||
                       (s_axi_araddr == tmr_pkg::ADDR_INT_STATUS) ||
                       (s_axi_araddr == tmr_pkg::ADDR_INT_CLEAR)  ||
                       (s_axi_araddr == tmr_pkg::ADDR_CONTROL)    ||
                       (s_axi_araddr == tmr_pkg::ADDR_INT_ENABLE) ||
                       (s_axi_araddr == tmr_pkg::ADDR_PORT_CTRL);
    assign rd_value  =
        (s_axi_araddr == tmr_pkg::ADDR_COUNT_LOW)  ? sixteen_bit_count_reg[7:0]  :
        (s_axi_araddr == tmr_pkg::ADDR_COUNT_HIGH) ? sixteen_bit_count_reg[15:8] :
        (s_axi_araddr == tmr_pkg::ADDR_INT_STATUS) ? {7'h00, overflow_flag_reg}  :
        (s_axi_araddr == tmr_pkg::ADDR_CONTROL)    ? ctrl_reg                    :
        (s_axi_araddr == tmr_pkg::ADDR_INT_ENABLE) ? {7'h00, overflow_int_enable_reg} :
        (s_axi_araddr == tmr_pkg::ADDR_PORT_CTRL)  ? port_ctrl_reg               : 8'h00;

    // ------------------------------------------------------------
    // Count source and phase sampling
    // ------------------------------------------------------------
    logic timer_mode;
    logic synced_path;
    logic src_level;
    logic presc_in;
    logic sample_now;
    logic tick_sync;
    logic tick_async;
    logic inc;
    logic overflow_evt;

    assign timer_mode  = ~ctrl_reg.clock_source_select;
    // sync bit only matters in counter mode
    assign synced_path = timer_mode | ~ctrl_reg.sync_disable;
    assign src_level   = ctrl_reg.osc_enable ? osc_input_pin_i : external_clock_pin_i;
    // instruction clock or pin edges; one high half per four clocks
    assign presc_in    = timer_mode ? (q_phase_reg[1] & ~sleep) : src_level;
    // Q2 and Q4 sampling; sampler off in sleep
    assign sample_now  = ((q_phase_reg == tmr_pkg::PHASE_Q2) ||
                          (q_phase_reg == tmr_pkg::PHASE_Q4)) & ~sleep;
    assign tick_sync   = samp_reg & ~samp_prev_reg;
    // unsynchronised path keeps running in sleep
    assign tick_async  = presc_out & ~presc_prev_reg;
    assign inc         = ctrl_reg.run_bit & (synced_path ? tick_sync : tick_async);
    // wrap event, lost when a write or clear replaces the count
    assign overflow_evt = inc & ~count_write & ~compare_reset &
                          (sixteen_bit_count_reg == tmr_pkg::COUNT_ALL_ONES);

    // prescaler ahead of the sampler; cleared by count writes
    tmr_prescaler u_prescaler (
        .aclk      (aclk),
        .aresetn   (aresetn),
        .in_level  (presc_in),
        .clear     (count_write),
        .sel       (ctrl_reg.prescale_select),
        .out_level (presc_out)
    );

    // ------------------------------------------------------------
    // Bus registers
    // ------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_reg   <= 1'b0;
            w_held_reg    <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= tmr_pkg::RESP_OKAY;
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rresp   <= tmr_pkg::RESP_OKAY;
            s_axi_rdata   <= 32'h0000_0000;
        end else begin
            aw_held_reg   <= aw_held_next;
            w_held_reg    <= w_held_next;
            s_axi_awready <= ~aw_held_next & ~bvalid_next;
            s_axi_wready  <= ~w_held_next & ~bvalid_next;
            s_axi_bvalid  <= bvalid_next;
            s_axi_arready <= ~rvalid_next;
            s_axi_rvalid  <= rvalid_next;
            if (do_write) begin
                s_axi_bresp <= wr_mapped ? tmr_pkg::RESP_OKAY : tmr_pkg::RESP_SLVERR;
            end
            if (ar_take) begin
                s_axi_rdata <= {24'h00_0000, rd_value};
                s_axi_rresp <= rd_mapped ? tmr_pkg::RESP_OKAY : tmr_pkg::RESP_SLVERR;
            end
        end
    end

    // Payload latches need no reset; held flags qualify them
    always_ff @(posedge aclk) begin
        if (aw_take) begin
            aw_addr_reg <= s_axi_awaddr;
        end
        if (w_take) begin
            w_data_reg  <= s_axi_wdata[7:0];
            w_lane0_reg <= s_axi_wstrb[0];
        end
    end

    // ------------------------------------------------------------
    // Control, interrupt and pin registers
    // ------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            // control cleared, timer stopped at 1:1
            ctrl_reg                <= tmr_pkg::CONTROL_RESET;
            overflow_flag_reg       <= 1'b0;
            overflow_int_enable_reg <= 1'b0;
            port_ctrl_reg           <= tmr_pkg::PORT_CTRL_RESET;
            q_phase_reg             <= 2'h0;
            presc_prev_reg          <= 1'b0;
            samp_reg                <= 1'b0;
            samp_prev_reg           <= 1'b0;
            count_known_reg         <= 2'h0;
            irq                     <= 1'b0;
            osc_amp_enable          <= 1'b0;
            osc_input_pin_oe        <= 1'b0;
            external_clock_pin_oe   <= 1'b0;
            osc_input_pin_o         <= 1'b0;
            external_clock_pin_o    <= 1'b0;
        end else begin
            q_phase_reg    <= q_phase_reg + 2'h1;
            presc_prev_reg <= presc_out;
            samp_prev_reg  <= samp_reg;
            count_known_reg <= count_known_reg | {wr_high, wr_low};
            if (sample_now) begin
                samp_reg <= presc_out;
            end
            if (wr_ctrl) begin
                ctrl_reg <= w_data_reg & tmr_pkg::CONTROL_WMASK;
            end
            if (wr_enable) begin
                overflow_int_enable_reg <= w_data_reg[tmr_pkg::OVF_BIT];
            end
            if (wr_port) begin
                port_ctrl_reg <= w_data_reg & tmr_pkg::PORT_CTRL_WMASK;
            end
            // sticky flag, a new wrap beats the clear
            overflow_flag_reg <= overflow_evt |
                (overflow_flag_reg & ~(wr_clear & w_data_reg[tmr_pkg::OVF_BIT]));
            irq <= overflow_flag_reg & overflow_int_enable_reg;
            osc_amp_enable <= ctrl_reg.osc_enable;
            // oscillator owns both pins, direction bits ignored
            osc_input_pin_oe      <= ~ctrl_reg.osc_enable &
                                     ~port_ctrl_reg[tmr_pkg::PORT_DIR_LSB + 1];
            external_clock_pin_oe <= ~ctrl_reg.osc_enable &
                                     ~port_ctrl_reg[tmr_pkg::PORT_DIR_LSB];
            osc_input_pin_o       <= port_ctrl_reg[tmr_pkg::PORT_DATA_LSB + 1];
            external_clock_pin_o  <= port_ctrl_reg[tmr_pkg::PORT_DATA_LSB];
        end
    end

    // ------------------------------------------------------------
    // Count register, kept through aresetn, cleared by compare_reset
    // ------------------------------------------------------------
    // no reset branch on purpose
    always_ff @(posedge aclk) begin
        if (count_write) begin
            if (wr_low) begin
                sixteen_bit_count_reg[7:0] <= w_data_reg;
            end
            if (wr_high) begin
                sixteen_bit_count_reg[15:8] <= w_data_reg;
            end
        // compare reset, a write takes precedence
        end else if (compare_reset) begin
            sixteen_bit_count_reg <= 16'h0000;
        end else if (inc) begin
            sixteen_bit_count_reg <= sixteen_bit_count_reg + 16'h0001;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    logic timer_steady;

    assign timer_steady = timer_mode & ctrl_reg.run_bit & ~sleep & ~count_write &
                          ~compare_reset & (ctrl_reg.prescale_select == tmr_pkg::PRESC_DIV1);

    sequence s_timer_tick;
        inc && timer_steady;
    endsequence

    sequence s_quiet_three;
        (timer_steady && !inc) [*3];
    endsequence

    a_count_wrap: assert property (@(posedge aclk) disable iff (!aresetn)
        overflow_evt |=> sixteen_bit_count_reg == 16'h0000 && overflow_flag_reg)
        else $error("wrap did not reach zero with flag");

    a_flag_sticky: assert property (@(posedge aclk) disable iff (!aresetn)
        overflow_flag_reg && !wr_clear |=> overflow_flag_reg)
        else $error("overflow flag dropped without a clear");

    a_irq_masked: assert property (@(posedge aclk) disable iff (!aresetn)
        !overflow_int_enable_reg |=> !irq)
        else $error("interrupt raised while masked");

    a_irq_follows: assert property (@(posedge aclk) disable iff (!aresetn)
        overflow_flag_reg && overflow_int_enable_reg |=> irq)
        else $error("enabled flag did not raise interrupt");

    a_timer_period: assert property (@(posedge aclk) disable iff (!aresetn)
        s_timer_tick ##1 s_quiet_three ##1 timer_steady |-> inc)
        else $error("timer mode missed its instruction cycle");

    a_timer_gap: assert property (@(posedge aclk) disable iff (!aresetn)
        s_timer_tick ##1 timer_steady |-> !inc)
        else $error("timer mode advanced twice in one cycle");

    a_stop_holds: assert property (@(posedge aclk) disable iff (!aresetn)
        &count_known_reg && !ctrl_reg.run_bit && !count_write && !compare_reset
            |=> $stable(sixteen_bit_count_reg))
        else $error("count moved while stopped");

    a_compare_clears: assert property (@(posedge aclk) disable iff (!aresetn)
        compare_reset && !count_write |=> sixteen_bit_count_reg == 16'h0000)
        else $error("compare reset did not clear count");

    a_osc_pins_in: assert property (@(posedge aclk) disable iff (!aresetn)
        ctrl_reg.osc_enable && $stable(ctrl_reg)
            |=> !osc_input_pin_oe && !external_clock_pin_oe)
        else $error("oscillator pin driven");

    a_sleep_hold: assert property (@(posedge aclk) disable iff (!aresetn)
        sleep && synced_path ##1 sleep && synced_path |-> !inc)
        else $error("synchronised count advanced in sleep");

    a_ctrl_upper: assert property (@(posedge aclk) disable iff (!aresetn)
        ctrl_reg.unused == 2'h0)
        else $error("unused control bits set");

endmodule

// ---- bench/tmr_clk_src.sv ----
`timescale 1ns/1ps
module tmr_clk_src (
    input  wire logic       aclk,
    input  wire logic       run,
    input  wire logic [3:0] half,
    output logic            pin
);
    // ------------------------------------------------
    // Burst source
    // ------------------------------------------------
    logic [3:0] cnt;

    initial begin
        pin = 1'b0;
        cnt = 4'h0;
    end

    // Stands low between bursts, so no stray edge leaks in
    always @(posedge aclk) begin
        if (!run) begin
            pin <= 1'b0;
            cnt <= 4'h0;
        end else if (cnt == half) begin
            pin <= ~pin;
            cnt <= 4'h0;
        end else begin
            cnt <= cnt + 4'h1;
        end
    end
endmodule

// ---- bench/testbench.sv ----
`timescale 1ns/1ps
module testbench;
    logic        aclk = 1'b0;
    logic        aresetn = 1'b0;
    logic [7:0]  s_axi_awaddr = 8'h00;
    logic        s_axi_awvalid = 1'b0;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0]  s_axi_wstrb = 4'hf;
    logic        s_axi_wvalid = 1'b0;
    logic [7:0]  s_axi_araddr = 8'h00;
    logic        s_axi_arvalid = 1'b0;
    logic        compare_reset = 1'b0;
    logic        sleep = 1'b0;
    logic        src_run = 1'b0;
    logic        to_osc = 1'b0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
    logic [31:0] s_axi_rdata, rdat, prev;
    logic        osc_input_pin_i, osc_input_pin_o, osc_input_pin_oe, src;
    logic        external_clock_pin_i, external_clock_pin_o, external_clock_pin_oe;
    logic        osc_amp_enable, irq;
    int          failures = 0;
    int          total_checks = 0;
    int          cycles = 0;

    always #2.5 aclk = ~aclk;

    // Ready lines held high: legal, and avoids same-step re-drives
    tmr_timer16 u_dut (
        .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready(1'b1), .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready(1'b1), .compare_reset, .sleep,
        .osc_input_pin_i, .osc_input_pin_o, .osc_input_pin_oe,
        .external_clock_pin_i, .external_clock_pin_o, .external_clock_pin_oe,
        .osc_amp_enable, .irq
    );
    tmr_clk_src u_src (.aclk, .run(src_run), .half(4'h3), .pin(src));

    // Wire follows the design whenever it drives the pin
    assign osc_input_pin_i = osc_input_pin_oe ? osc_input_pin_o : (to_osc & src);
    assign external_clock_pin_i = external_clock_pin_oe ? external_clock_pin_o : (~to_osc & src);

    // ------------------------------------------------
    // Bus and compare tasks
    // ------------------------------------------------
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h0, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        resp = s_axi_bresp;
    endtask

    task automatic rd(input logic [7:0] a);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        rdat = s_axi_rdata;
        resp = s_axi_rresp;
    endtask

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
        total_checks++;
        if (s !== e) begin
            failures++;
            $display("Error %s expected %h seen %h", nm, e, s);
        end
    endtask

    task automatic complete_run;
        if (failures == 0 && total_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    always @(posedge aclk) begin
        cycles++;
        if (cycles == 20000) begin
            failures++;
            complete_run();
        end
    end

    // ------------------------------------------------
    // Scenarios
    // ------------------------------------------------
    // Mode settles with the run bit off, so a switch of source cannot leave a stray tick
    task automatic start(input logic [7:0] ctl);
        wr(8'h10, ctl & 8'hfe);
        wr(8'h00, 8'h00);
        wr(8'h04, 8'h00);
        wr(8'h10, ctl);
    endtask

    task automatic edges(input int k);
        src_run <= 1'b1;
        repeat (8 * k) @(posedge aclk);
        src_run <= 1'b0;
        repeat (8) @(posedge aclk);
    endtask

    task automatic t_regs;
        rd(8'h10);
        chk("control reset", 32'h0, rdat);
        wr(8'h10, 8'hfe);
        rd(8'h10);
        chk("control unused", 32'h3e, rdat);
        s_axi_wstrb <= 4'he;
        wr(8'h10, 8'h00);
        s_axi_wstrb <= 4'hf;
        rd(8'h10);
        chk("lane0 strobe off", 32'h3e, rdat);
        wr(8'h04, 8'h5a);
        rd(8'h04);
        chk("count high", 32'h5a, rdat);
        wr(8'h20, 8'h01);
        chk("unmapped write", 32'h2, resp);
        rd(8'h20);
        chk("unmapped read", 32'h2, resp);
        wr(8'h10, 8'h00);
        wr(8'h18, 8'h20);
        @(posedge aclk);
        chk("pin drive", 32'he, {osc_input_pin_oe, external_clock_pin_oe,
            osc_input_pin_o, external_clock_pin_o});
        wr(8'h10, 8'h08);
        @(posedge aclk);
        chk("pins forced", 32'h1, {osc_input_pin_oe, external_clock_pin_oe, osc_amp_enable});
        wr(8'h18, 8'hc0);
    endtask

    task automatic t_overflow;
        start(8'h00);
        wr(8'h14, 8'h01);
        wr(8'h00, 8'hfe);
        wr(8'h04, 8'hff);
        wr(8'h10, 8'h01);
        repeat (20) @(posedge aclk);
        wr(8'h10, 8'h00);
        rd(8'h04);
        chk("wrapped high", 32'h0, rdat);
        rd(8'h08);
        chk("flag", 32'h1, rdat);
        chk("irq", 32'h1, irq);
        wr(8'h14, 8'h00);
        @(posedge aclk);
        chk("irq masked", 32'h0, irq);
        wr(8'h0c, 8'h01);
        rd(8'h08);
        chk("flag cleared", 32'h0, rdat);
        compare_reset <= 1'b1;
        @(posedge aclk);
        compare_reset <= 1'b0;
        rd(8'h00);
        chk("compare clear", 32'h0, rdat);
    endtask

    // Bus latency blurs both ends of the window by one tick
    task automatic t_timer;
        for (int c = 0; c < 4; c++) begin
            start({2'h0, c[1:0], 4'h1});
            repeat (256) @(posedge aclk);
            wr(8'h10, 8'h00);
            rd(8'h00);
            chk("timer rate", 32'h1, (rdat + 1 - (64 >> c)) <= 2);
        end
        prev = rdat;
        repeat (40) @(posedge aclk);
        rd(8'h00);
        chk("stopped count", prev, rdat);
    endtask

    task automatic t_counter;
        for (int c = 0; c < 4; c++) begin
            start({2'h0, c[1:0], 4'h3});
            edges(8);
            rd(8'h00);
            chk("prescaled edges", 32'h8 >> c, rdat);
        end
        to_osc <= 1'b1;
        start(8'h0b);
        edges(2);
        rd(8'h00);
        chk("osc pin edges", 32'h2, rdat);
        to_osc <= 1'b0;
        start(8'h33);
        edges(4);
        wr(8'h00, 8'h00);
        edges(4);
        rd(8'h00);
        // Cleared stages rise again after four edges; stale ones would fall instead
        chk("prescaler cleared", 32'h1, rdat);
    endtask

    task automatic t_sleep;
        sleep <= 1'b1;
        start(8'h03);
        edges(4);
        rd(8'h00);
        chk("sync sleep", 32'h0, rdat);
        start(8'h07);
        edges(4);
        rd(8'h00);
        chk("async sleep", 32'h4, rdat);
        sleep <= 1'b0;
    endtask

    initial begin
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        t_regs();
        t_overflow();
        t_timer();
        t_counter();
        t_sleep();
        complete_run();
    end
endmodule
